// >>> rsrm_consts.vh
`ifndef RSRM_CONSTS_VH
`define RSRM_CONSTS_VH

// register addresses
`define RSRM_ADDR_REVISION 6'h00
`define RSRM_ADDR_SYNTH_A 6'h01
`define RSRM_ADDR_SYNTH_N 6'h02
`define RSRM_ADDR_CONTROL 6'h03
`define RSRM_ADDR_RATE 6'h04
`define RSRM_ADDR_CONFIG 6'h05
`define RSRM_ADDR_SERIALIZER 6'h06
`define RSRM_ADDR_RX_IRQ_EN 6'h07
`define RSRM_ADDR_RX_IRQ_STAT 6'h08
`define RSRM_ADDR_RX_BYTE_1 6'h09
`define RSRM_ADDR_RX_VALID_1 6'h0A
`define RSRM_ADDR_RX_BYTE_2 6'h0B
`define RSRM_ADDR_RX_VALID_2 6'h0C
`define RSRM_ADDR_TX_IRQ_EN 6'h0D
`define RSRM_ADDR_TX_IRQ_STAT 6'h0E
`define RSRM_ADDR_TX_BYTE 6'h0F
`define RSRM_ADDR_TX_VALID 6'h10
`define RSRM_ADDR_CODE_LO 6'h11
`define RSRM_ADDR_CODE_HI 6'h18
`define RSRM_ADDR_THRESH_LO 6'h19
`define RSRM_ADDR_THRESH_HI 6'h1A
`define RSRM_ADDR_WAKE_EN 6'h1C
`define RSRM_ADDR_WAKE_STAT 6'h1D
`define RSRM_ADDR_ANALOG 6'h20
`define RSRM_ADDR_CHANNEL 6'h21
`define RSRM_ADDR_STRENGTH 6'h22
`define RSRM_ADDR_POWER 6'h23
`define RSRM_ADDR_OSC_TRIM 6'h24
`define RSRM_ADDR_OSC_CAL 6'h26
`define RSRM_ADDR_GAIN 6'h2E
`define RSRM_ADDR_CARRIER 6'h2F
`define RSRM_ADDR_CLK_OVR 6'h32
`define RSRM_ADDR_CLK_GATE 6'h33
`define RSRM_ADDR_SETTLE 6'h38
`define RSRM_ADDR_FACTORY_0 6'h3C
`define RSRM_ADDR_FACTORY_1 6'h3D
`define RSRM_ADDR_FACTORY_2 6'h3E
`define RSRM_ADDR_FACTORY_3 6'h3F

// reset values of writable registers
`define RSRM_RST_ZERO 8'h00
`define RSRM_RST_CONFIG 8'h01
`define RSRM_RST_SERIALIZER 8'h03
`define RSRM_RST_CODE 64'h1E8B6A3DE0E9B222
`define RSRM_RST_THRESH_LO 8'h08
`define RSRM_RST_THRESH_HI 8'h38
`define RSRM_RST_ANALOG 8'h04
`define RSRM_RST_SETTLE 8'h64

// field positions
`define RSRM_CHAN_DIRECT_BIT 7
`define RSRM_CHAN_NUM_MSB 6
`define RSRM_A_MSB 4
`define RSRM_N_MSB 6
`define RSRM_CMD_WRITE_BIT 7
`define RSRM_CMD_ADDR_MSB 5

// channel to counter mapping: total = base + channel, n = total/32
`define RSRM_SYNTH_BASE 12'h940
`define RSRM_A_BITS 5

// identity fields, arbitrary neutral values
`define RSRM_SILICON_REV 4'h3
`define RSRM_PRODUCT 4'hA

`define RSRM_BIT_LAST 3'h7

`endif

// >>> rsrm_register_map.v
// Function
// - host reads and writes every mapped register over spi, except read-only ones
// - spreading code and factory id are little endian, low byte lowest address
// - revision upper nibble holds the read-only silicon revision code
// - revision lower nibble holds a fixed read-only product code
// - synth a count is five bits, every value 0 to 31 valid
// - channel bit 7 picks channel number or direct a and n counters
// - in channel mode a and n reads return channel-derived values
// - direct mode frequency built from a count and n count
// - synth n count is seven bits, top bit reserved, valid 74 to 77
`timescale 1ns/10ps
`default_nettype none
`include "rsrm_consts.vh"

module rsrm_register_map #(
  parameter [3:0] SILICON_REV = `RSRM_SILICON_REV,
  parameter [3:0] PRODUCT = `RSRM_PRODUCT
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_spi_sck,
  input wire i_spi_ss_n,
  input wire i_spi_mosi,
  output wire o_spi_miso,
  output wire o_spi_miso_oe,
  input wire [7:0] i_rx_irq_status,
  input wire [7:0] i_rx_byte_first,
  input wire [7:0] i_rx_valid_first,
  input wire [7:0] i_rx_byte_second,
  input wire [7:0] i_rx_valid_second,
  input wire [7:0] i_tx_irq_status,
  input wire [7:0] i_wake_status,
  input wire [7:0] i_signal_strength,
  input wire [31:0] i_factory_id,
  output wire [4:0] o_synth_a,
  output wire [6:0] o_synth_n,
  output wire o_synth_direct,
  output wire [7:0] o_radio_control,
  output wire [63:0] o_spreading_code
);

  reg [7:0] mem_ff [0:63];
  reg sck_prev_ff;
  reg [2:0] bit_cnt_ff;
  reg cmd_phase_ff;
  reg wr_mode_ff;
  reg [5:0] addr_ff;
  reg [7:0] rx_sh_ff;
  reg [7:0] tx_sh_ff;
  reg miso_ff;
  reg miso_oe_ff;
  reg [4:0] synth_a_ff;
  reg [6:0] synth_n_ff;
  reg synth_direct_ff;
  reg [7:0] rdata;
  reg [63:0] code_cat;
  wire [7:0] nxt_rx_sh;
  wire sck_rise;
  wire sck_fall;
  wire [11:0] chan_total;
  wire [4:0] chan_a;
  wire [6:0] chan_n;
  wire direct_sel;
  wire [5:0] nxt_addr;
  integer i;
  integer k;

  // reset value of each location; read-only and unmapped hold zero
  function [7:0] rst_val;
    input [5:0] a;
    reg [63:0] code_sh;
    begin
      // byte of the code picked by shifting, then cut to one byte
      code_sh = `RSRM_RST_CODE >> {a - `RSRM_ADDR_CODE_LO, 3'h0};
      rst_val = `RSRM_RST_ZERO;
      if (a == `RSRM_ADDR_CONFIG) begin
        rst_val = `RSRM_RST_CONFIG;
      end else if (a == `RSRM_ADDR_SERIALIZER) begin
        rst_val = `RSRM_RST_SERIALIZER;
      end else if (a >= `RSRM_ADDR_CODE_LO && a <= `RSRM_ADDR_CODE_HI) begin
        rst_val = code_sh[7:0];
      end else if (a == `RSRM_ADDR_THRESH_LO) begin
        rst_val = `RSRM_RST_THRESH_LO;
      end else if (a == `RSRM_ADDR_THRESH_HI) begin
        rst_val = `RSRM_RST_THRESH_HI;
      end else if (a == `RSRM_ADDR_ANALOG) begin
        rst_val = `RSRM_RST_ANALOG;
      end else if (a == `RSRM_ADDR_SETTLE) begin
        rst_val = `RSRM_RST_SETTLE;
      end
    end
  endfunction

  // writable map; read-only and holes refuse the write
  function writable;
    input [5:0] a;
    begin
      writable = 1'b0;
      // one branch per register, register pair or code range so a map edit touches one line pair
      if (a == `RSRM_ADDR_SYNTH_A) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_SYNTH_N) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_CONTROL) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_RATE) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_CONFIG) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_SERIALIZER) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_RX_IRQ_EN) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_TX_IRQ_EN) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_TX_BYTE) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_TX_VALID) begin
        writable = 1'b1;
      end else if (a >= `RSRM_ADDR_CODE_LO && a <= `RSRM_ADDR_CODE_HI) begin
        // whole spreading code is host writable, byte by byte
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_THRESH_LO) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_THRESH_HI) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_WAKE_EN) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_ANALOG || a == `RSRM_ADDR_CHANNEL) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_POWER || a == `RSRM_ADDR_OSC_TRIM) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_OSC_CAL) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_GAIN || a == `RSRM_ADDR_CARRIER) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_CLK_OVR || a == `RSRM_ADDR_CLK_GATE) begin
        writable = 1'b1;
      end else if (a == `RSRM_ADDR_SETTLE) begin
        writable = 1'b1;
      end
    end
  endfunction

  assign sck_rise = ~i_spi_ss_n & i_spi_sck & ~sck_prev_ff;
  assign sck_fall = ~i_spi_ss_n & ~i_spi_sck & sck_prev_ff;
  assign nxt_rx_sh = {rx_sh_ff[6:0], i_spi_mosi};
  assign nxt_addr = addr_ff + 6'h01;

  // channel number mapped onto the dual-modulus counters
  assign direct_sel = mem_ff[`RSRM_ADDR_CHANNEL][`RSRM_CHAN_DIRECT_BIT];
  assign chan_total = `RSRM_SYNTH_BASE +
    {5'h00, mem_ff[`RSRM_ADDR_CHANNEL][`RSRM_CHAN_NUM_MSB:0]};
  assign chan_a = chan_total[`RSRM_A_BITS-1:0];
  assign chan_n = chan_total[11:`RSRM_A_BITS];

  // read mux; in channel mode the counters show derived values
  always @* begin
    rdata = mem_ff[addr_ff];
    if (addr_ff == `RSRM_ADDR_REVISION) begin
      rdata = {SILICON_REV, PRODUCT};
    end else if (addr_ff == `RSRM_ADDR_SYNTH_A && !direct_sel) begin
      rdata = {3'h0, chan_a};
    end else if (addr_ff == `RSRM_ADDR_SYNTH_N && !direct_sel) begin
      rdata = {1'b0, chan_n};
    end else if (addr_ff == `RSRM_ADDR_RX_IRQ_STAT) begin
      rdata = i_rx_irq_status;
    end else if (addr_ff == `RSRM_ADDR_RX_BYTE_1) begin
      rdata = i_rx_byte_first;
    end else if (addr_ff == `RSRM_ADDR_RX_VALID_1) begin
      rdata = i_rx_valid_first;
    end else if (addr_ff == `RSRM_ADDR_RX_BYTE_2) begin
      rdata = i_rx_byte_second;
    end else if (addr_ff == `RSRM_ADDR_RX_VALID_2) begin
      rdata = i_rx_valid_second;
    end else if (addr_ff == `RSRM_ADDR_TX_IRQ_STAT) begin
      rdata = i_tx_irq_status;
    end else if (addr_ff == `RSRM_ADDR_WAKE_STAT) begin
      rdata = i_wake_status;
    end else if (addr_ff == `RSRM_ADDR_STRENGTH) begin
      rdata = i_signal_strength;
    end else if (addr_ff == `RSRM_ADDR_FACTORY_0) begin
      rdata = i_factory_id[7:0];
    end else if (addr_ff == `RSRM_ADDR_FACTORY_1) begin
      rdata = i_factory_id[15:8];
    end else if (addr_ff == `RSRM_ADDR_FACTORY_2) begin
      rdata = i_factory_id[23:16];
    end else if (addr_ff == `RSRM_ADDR_FACTORY_3) begin
      rdata = i_factory_id[31:24];
    end
  end

  // spi framing: command byte then data bytes, address auto-increments
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      sck_prev_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      cmd_phase_ff <= 1'b1;
      wr_mode_ff <= 1'b0;
      addr_ff <= 6'h00;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      sck_prev_ff <= i_spi_sck;
      miso_oe_ff <= ~i_spi_ss_n;
      if (i_spi_ss_n) begin
        // deselect aborts any partial byte
        bit_cnt_ff <= 3'h0;
        cmd_phase_ff <= 1'b1;
        tx_sh_ff <= 8'h00;
        miso_ff <= 1'b0;
      end else if (sck_rise) begin
        rx_sh_ff <= nxt_rx_sh;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == `RSRM_BIT_LAST) begin
          cmd_phase_ff <= 1'b0;
          if (cmd_phase_ff) begin
            wr_mode_ff <= nxt_rx_sh[`RSRM_CMD_WRITE_BIT];
            addr_ff <= nxt_rx_sh[`RSRM_CMD_ADDR_MSB:0];
            tx_sh_ff <= 8'h00;
          end else begin
            // multi-byte fields walk upward from the low byte
            addr_ff <= nxt_addr;
            tx_sh_ff <= 8'h00;
          end
        end
      end else if (sck_fall) begin
        if (bit_cnt_ff == 3'h0 && !cmd_phase_ff && !wr_mode_ff) begin
          // load on the first fall so the address is already settled
          miso_ff <= rdata[7];
          tx_sh_ff <= {rdata[6:0], 1'b0};
        end else begin
          miso_ff <= tx_sh_ff[7];
          tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
        end
      end
    end
  end

  // register storage; only writable locations ever change
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      for (i = 0; i < 64; i = i + 1) begin
        mem_ff[i] <= rst_val(i[5:0]);
      end
    end else if (sck_rise && bit_cnt_ff == `RSRM_BIT_LAST && !cmd_phase_ff &&
                 wr_mode_ff && writable(addr_ff)) begin
      // stored whole; host keeps reserved bits zero
      mem_ff[addr_ff] <= nxt_rx_sh;
    end
  end

  // synthesizer drive; channel mode recommended, direct for diagnostics
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      synth_a_ff <= 5'h00;
      synth_n_ff <= 7'h00;
      synth_direct_ff <= 1'b0;
    end else begin
      synth_direct_ff <= direct_sel;
      if (direct_sel) begin
        synth_a_ff <= mem_ff[`RSRM_ADDR_SYNTH_A][`RSRM_A_MSB:0];
        synth_n_ff <= mem_ff[`RSRM_ADDR_SYNTH_N][`RSRM_N_MSB:0];
      end else begin
        synth_a_ff <= chan_a;
        synth_n_ff <= chan_n;
      end
    end
  end

  // spreading code gathered low byte first
  always @* begin
    code_cat = 64'h0000000000000000;
    for (k = 0; k < 8; k = k + 1) begin
      code_cat[k*8 +: 8] = mem_ff[`RSRM_ADDR_CODE_LO + k];
    end
  end

  assign o_spi_miso = miso_ff;
  assign o_spi_miso_oe = miso_oe_ff;
  assign o_synth_a = synth_a_ff;
  assign o_synth_n = synth_n_ff;
  assign o_synth_direct = synth_direct_ff;
  assign o_radio_control = mem_ff[`RSRM_ADDR_CONTROL];
  assign o_spreading_code = code_cat;

endmodule

`default_nettype wire

// >>> rsrm_map_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rsrm_map_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_spi_sck,
  input wire logic i_spi_ss_n,
  input wire logic o_spi_miso,
  input wire logic o_spi_miso_oe,
  input wire logic [4:0] o_synth_a,
  input wire logic [6:0] o_synth_n,
  input wire logic o_synth_direct,
  input wire logic [7:0] o_radio_control,
  input wire logic [63:0] o_spreading_code
);
  logic sck_ff;
  logic [3:0] falls_ff;
  // edges as the block sees them: raw sck sampled by the core clock
  wire rise = i_spi_sck & ~sck_ff;
  wire fall = ~i_spi_sck & sck_ff;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // falls since select, saturating so long bursts never wrap
  always @(posedge i_core_clk) begin
    sck_ff <= i_spi_sck & ~i_rst;
    if (i_rst | i_spi_ss_n) falls_ff <= 4'h0;
    else if (fall && falls_ff != 4'hF) falls_ff <= falls_ff + 4'h1;
  end
  property p_oe_on;
    $fell(i_spi_ss_n) |=> o_spi_miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("enable late");
  property p_oe_off;
    i_spi_ss_n |=> !o_spi_miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("enable stuck");
  property p_cmd_quiet;
    o_spi_miso_oe && falls_ff inside {[1:6]} |-> !o_spi_miso;
  endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("cmd miso");
  property p_miso_edge;
    $changed(o_spi_miso) && o_spi_miso_oe && $past(o_spi_miso_oe)
      |-> $past(fall, 1) || $past(fall, 2) || $past(fall, 3);
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved");
  property p_ctl_chg;
    $changed(o_radio_control) |-> $past(rise, 1) || $past(rise, 2);
  endproperty
  a_ctl_chg: assert property (p_ctl_chg) else $error("ctl moved");
  property p_code_chg;
    $changed(o_spreading_code) |-> $past(rise) && !$past(i_spi_ss_n);
  endproperty
  a_code_chg: assert property (p_code_chg) else $error("code moved");
  // derived counters may lag the write by a cycle or two
  property p_syn_chg;
    $changed({o_synth_a, o_synth_n, o_synth_direct}) && !$past(i_rst, 1)
      && !$past(i_rst, 2) && !$past(i_rst, 3)
      |-> $past(rise, 1) || $past(rise, 2) || $past(rise, 3);
  endproperty
  a_syn_chg: assert property (p_syn_chg) else $error("synth moved");
  property p_chan_rng;
    !o_synth_direct && $stable(o_synth_direct) && !$past(i_rst)
      && !$past(i_rst, 2) |-> o_synth_n inside {[74:77]};
  endproperty
  a_chan_rng: assert property (p_chan_rng) else $error("n range");
endmodule
bind rsrm_register_map rsrm_map_monitor rsrm_map_monitor_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_spi_sck(i_spi_sck),
  .i_spi_ss_n(i_spi_ss_n), .o_spi_miso(o_spi_miso),
  .o_spi_miso_oe(o_spi_miso_oe), .o_synth_a(o_synth_a),
  .o_synth_n(o_synth_n), .o_synth_direct(o_synth_direct),
  .o_radio_control(o_radio_control), .o_spreading_code(o_spreading_code));
`default_nettype wire

// >>> rsrm_spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rsrm_spi_host_model (
  input wire logic i_core_clk,
  input wire logic i_miso,
  output var logic o_sck,
  output var logic o_ss_n,
  output var logic o_mosi
);
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b1;
  end
  // three core cycles per level, above the two the block needs
  task automatic wt;
    repeat (3) @(negedge i_core_clk);
  endtask
  // command, then nb data bytes, lowest address first
  task automatic frame(input logic [7:0] cmd, input logic [63:0] wd,
      input int nb, output logic [63:0] rd);
    logic [7:0] b;
    rd = '0;
    @(negedge i_core_clk);
    o_ss_n = 1'b0;
    for (int k = -1; k < nb; k++) begin
      b = (k < 0) ? cmd : wd[8*k +: 8];
      for (int i = 7; i >= 0; i--) begin
        o_mosi = b[i];
        o_sck = 1'b0;
        wt();
        if (k >= 0) rd[8*k+i] = i_miso;
        o_sck = 1'b1;
        wt();
      end
    end
    o_sck = 1'b0;
    o_mosi = ~o_mosi; // no stale data once released
    wt();
    o_ss_n = 1'b1;
    wt();
  endtask
endmodule
`default_nettype wire

// >>> radio_spi_register_map_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module radio_spi_register_map_tb_top;
  localparam logic [3:0] REV = 4'h5; // arbitrary
  localparam logic [3:0] PROD = 4'hC; // arbitrary
  logic i_core_clk, i_rst, sck, ss_n, mosi, miso, sd;
  logic [7:0] ro [8];
  logic [7:0] ctl, ch;
  logic [31:0] fid;
  logic [4:0] sa, a;
  logic [6:0] sn, n;
  logic [11:0] t;
  logic [63:0] code, rd, wv;
  int fail_count = 0, n_tests = 0;
  // address and reset value of the plain writable registers
  logic [15:0] rwt [20] = '{16'h0300, 16'h0400, 16'h0501, 16'h0603,
    16'h0700, 16'h0D00, 16'h0F00, 16'h1000, 16'h1908, 16'h1A38, 16'h1C00,
    16'h2004, 16'h2300, 16'h2400, 16'h2600, 16'h2E00, 16'h2F00, 16'h3200,
    16'h3300, 16'h3864};
  logic [5:0] roa [8] = '{6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0E,
    6'h1D, 6'h22};
  rsrm_register_map #(.SILICON_REV(REV), .PRODUCT(PROD))
      rsrm_register_map_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_spi_sck(sck), .i_spi_ss_n(ss_n), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .o_spi_miso_oe(), .i_rx_irq_status(ro[0]),
    .i_rx_byte_first(ro[1]), .i_rx_valid_first(ro[2]),
    .i_rx_byte_second(ro[3]), .i_rx_valid_second(ro[4]),
    .i_tx_irq_status(ro[5]), .i_wake_status(ro[6]),
    .i_signal_strength(ro[7]), .i_factory_id(fid), .o_synth_a(sa),
    .o_synth_n(sn), .o_synth_direct(sd), .o_radio_control(ctl),
    .o_spreading_code(code));
  rsrm_spi_host_model rsrm_spi_host_model_i (.i_core_clk(i_core_clk),
    .i_miso(miso), .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi));
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic xf(input logic w, input logic [5:0] ad,
      input logic [63:0] v, input int nb);
    rsrm_spi_host_model_i.frame({w, 1'b0, ad}, v, nb, rd);
  endtask
  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge i_core_clk);
    fail_count++;
    $display("[FAIL] %0t run did not finish", $time);
    summarize();
  end
  initial begin
    wv = $urandom(41775);
    i_rst = 1'b1;
    fid = $urandom;
    foreach (ro[k]) ro[k] = $urandom;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    @(negedge i_core_clk);
    chk({sd, sa, sn}, {1'b0, 5'h00, 7'h4A});
    foreach (rwt[k]) begin
      xf(1'b0, rwt[k][13:8], 64'h0, 1);
      chk(rd[7:0], rwt[k][7:0]);
      wv = $urandom;
      xf(1'b1, rwt[k][13:8], wv, 1);
      xf(1'b0, rwt[k][13:8], 64'h0, 1);
      chk(rd[7:0], wv[7:0]);
      if (rwt[k][15:8] == 8'h03) chk(ctl, wv[7:0]);
    end
    // identity is fixed whatever the host writes
    xf(1'b1, 6'h00, 64'hFF, 1);
    xf(1'b0, 6'h00, 64'h0, 1);
    chk(rd[7:0], {REV, PROD});
    foreach (roa[k]) begin
      xf(1'b1, roa[k], {56'h0, ~ro[k]}, 1);
      xf(1'b0, roa[k], 64'h0, 1);
      chk(rd[7:0], ro[k]);
    end
    xf(1'b1, 6'h3C, {32'h0, ~fid}, 4);
    xf(1'b0, 6'h3C, 64'h0, 4);
    chk(rd[31:0], fid);
    xf(1'b0, 6'h11, 64'h0, 8);
    chk(rd, 64'h1E8B6A3DE0E9B222);
    wv = {$urandom, $urandom};
    xf(1'b1, 6'h11, wv, 8);
    chk(code, wv);
    xf(1'b0, 6'h11, 64'h0, 8);
    chk(rd, wv);
    xf(1'b1, 6'h1B, 64'h5A, 1);
    xf(1'b0, 6'h1B, 64'h0, 1);
    chk(rd[7:0], 8'h00);
    for (int i = 0; i < 12; i++) begin
      ch = (i == 1) ? 8'h7F : (i == 0) ? 8'h00 : $urandom;
      ch[7] = (i >= 6);
      xf(1'b1, 6'h21, {56'h0, ch}, 1);
      t = 12'h940 + {5'h0, ch[6:0]};
      a = (i < 6) ? t[4:0] : (i == 6) ? 5'h00 : (i == 7) ? 5'h1F : $urandom;
      n = (i < 6) ? t[11:5] : 7'd74 + 7'(i % 3);
      if (i >= 6) xf(1'b1, 6'h01, {48'h0, 1'b0, n, 3'h0, a}, 2);
      chk({sd, sa, sn}, {ch[7], a, n});
      xf(1'b0, 6'h01, 64'h0, 2);
      chk(rd[15:0], {1'b0, n, 3'h0, a});
    end
    // reset in mid-run brings every register back to its default
    i_rst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    @(negedge i_core_clk);
    chk(ctl, 64'h00);
    chk(code, 64'h1E8B6A3DE0E9B222);
    chk({sd, sa, sn}, {1'b0, 5'h00, 7'h4A});
    xf(1'b0, 6'h21, 64'h0, 1);
    chk(rd[7:0], 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
